// ### include/mbrf_consts.vh
// Constants for the mode-banked register file
`ifndef MBRF_CONSTS_VH
`define MBRF_CONSTS_VH
`define MBRF_MODE_USR 5'h10
`define MBRF_MODE_FIQ 5'h11
`define MBRF_MODE_IRQ 5'h12
`define MBRF_MODE_SVC 5'h13
`define MBRF_MODE_ABT 5'h17
`define MBRF_MODE_UND 5'h1B
`define MBRF_MODE_SYS 5'h1F
`define MBRF_MODE_RESET 5'h13
`define MBRF_BANK_USR 3'h0
`define MBRF_BANK_SVC 3'h1
`define MBRF_BANK_ABT 3'h2
`define MBRF_BANK_UND 3'h3
`define MBRF_BANK_IRQ 3'h4
`define MBRF_BANK_FIQ 3'h5
`define MBRF_PC_INDEX 4'hF
`define MBRF_NUM_PHYS 6'h1F
`define MBRF_NUM_STATUS 3'h6
`endif

// ### rtl/mbrf_mode_decode.v
// Mode code decoder for the banked register file
`timescale 1ns/1ps
`include "mbrf_consts.vh"
module mbrf_mode_decode (
	mode,
	bank,
	privileged,
	exception_mode,
	valid_mode
);
	input wire [4:0] mode;
	output reg [2:0] bank;
	output reg privileged;
	output reg exception_mode;
	output reg valid_mode;

	// Map mode code to bank and privilege class
	always @* begin
		bank = `MBRF_BANK_USR;
		privileged = 1'b1;
		exception_mode = 1'b0;
		valid_mode = 1'b1;
		case (mode)
			`MBRF_MODE_USR: begin
				privileged = 1'b0; // RULE_01
			end
			`MBRF_MODE_SYS: begin
				bank = `MBRF_BANK_USR; // RULE_01
			end
			`MBRF_MODE_FIQ: begin
				bank = `MBRF_BANK_FIQ; // RULE_02
				exception_mode = 1'b1;
			end
			`MBRF_MODE_IRQ: begin
				bank = `MBRF_BANK_IRQ; // RULE_02
				exception_mode = 1'b1;
			end
			`MBRF_MODE_SVC: begin
				bank = `MBRF_BANK_SVC; // RULE_02
				exception_mode = 1'b1;
			end
			`MBRF_MODE_ABT: begin
				bank = `MBRF_BANK_ABT; // RULE_03
				exception_mode = 1'b1;
			end
			`MBRF_MODE_UND: begin
				bank = `MBRF_BANK_UND; // RULE_03
				exception_mode = 1'b1;
			end
			default: begin
				privileged = 1'b0; // RULE_17
				valid_mode = 1'b0;
			end
		endcase
	end
endmodule

// ### rtl/mbrf_regfile.v
// Mode-banked register file with mode control
// Notes on behaviour
// RULE_01: Code 10000 is unprivileged, 11111 privileged user; both use unbanked set.
// RULE_02: Codes 10001, 10010, 10011 are fast interrupt, interrupt, supervisor exception modes.
// RULE_03: Codes 10111 and 11011 are abort and illegal opcode exception modes.
// RULE_04: Thirty-seven physical registers: thirty-one general, six status.
// RULE_05: Status registers are 32 bits; only needed bits implemented.
// RULE_06: Indices 0 to 14, program counter and status registers always visible.
// RULE_07: Indices 0 to 7 are one shared register each in every mode.
// RULE_08: Mode selects partially overlapping banks of physical registers.
// RULE_09: Fast interrupt banks 8-14; others bank 13-14; exception modes own saved status.
// RULE_10: Privileged user mode sees user registers and no saved status.
// RULE_11: Exceptions never enter privileged user mode.
// RULE_12: Unprivileged mode blocks software mode change and protected access.
// RULE_13: Privileged modes get full access and free mode changes.
// RULE_14: Taking an exception switches to its matching exception mode.
// RULE_15: Indices 8 to 12 have fast interrupt copy and shared copy.
// RULE_16: Indices 13 and 14 have six copies, user plus five exception modes.
// RULE_17: Undefined mode codes map to unprivileged bank.
// RULE_18: Reset starts in a privileged exception mode; contents undefined until written.
`timescale 1ns/1ps
`include "mbrf_consts.vh"
module mbrf_regfile #(
	parameter STATUS_MASK = 32'hFFFFFFFF,
	parameter RESET_MODE = `MBRF_MODE_RESET
) (
	input wire ref_clk,
	input wire rst,
	input wire [3:0] rd_a_idx,
	output wire [31:0] rd_a_data,
	input wire [3:0] rd_b_idx,
	output wire [31:0] rd_b_data,
	input wire wr_en,
	input wire [3:0] wr_idx,
	input wire [31:0] wr_data,
	input wire pc_wr_en,
	input wire [31:0] pc_wr_data,
	output wire [31:0] program_counter,
	output wire [31:0] current_status_reg,
	input wire cur_status_wr_en,
	input wire [31:0] cur_status_wr_data,
	output wire [31:0] saved_status_reg,
	output wire saved_status_valid,
	input wire saved_status_wr_en,
	input wire [31:0] saved_status_wr_data,
	input wire exc_take,
	input wire [2:0] exc_bank,
	input wire [31:0] exc_return_addr,
	output wire [4:0] mode,
	output wire privileged,
	output wire in_exception_mode,
	output wire mode_change_blocked,
	output wire resource_access_ok
);
	// Reset mode code at the width of the mode field
	localparam [4:0] RESET_CODE = RESET_MODE;

	// Physical storage: 16 general incl. program counter, 15 banked copies
	// Shared slots 8..14 live in gpr_q; the fast interrupt set has its own
	reg [31:0] gpr_q [0:15]; // RULE_04 RULE_07
	reg [31:0] fast_bank_q [8:14]; // RULE_15
	reg [31:0] bank13_q [1:4]; // RULE_16
	reg [31:0] bank14_q [1:4]; // RULE_16
	reg [31:0] saved_q [1:5]; // RULE_09
	reg [31:0] status_q; // RULE_04
	reg [31:0] status_d;
	reg blocked_q;
	reg blocked_d;
	reg [4:0] exc_mode;
	wire [2:0] bank;
	wire priv_w;
	wire exc_w;
	wire [2:0] exc_slot;
	wire [2:0] cur_slot;
	wire [31:0] status_masked;
	wire [31:0] user_merge;

	// Mode decode from the live status register
	mbrf_mode_decode u_dec (
		.mode(status_q[4:0]),
		.bank(bank),
		.privileged(priv_w),
		.exception_mode(exc_w),
		.valid_mode()
	);

	// Saved status slot of a bank; unknown banks fall back to supervisor
	function [2:0] slot_of;
		input [2:0] bk;
		begin
			case (bk)
				`MBRF_BANK_ABT: slot_of = 3'h2;
				`MBRF_BANK_UND: slot_of = 3'h3;
				`MBRF_BANK_IRQ: slot_of = 3'h4;
				`MBRF_BANK_FIQ: slot_of = 3'h5;
				default: slot_of = 3'h1;
			endcase
		end
	endfunction

	// Physical read selection by current bank
	// Decoder only yields banks 0..5, so array bounds are never exceeded
	function [31:0] rd_sel;
		input [3:0] idx;
		input [2:0] bk;
		begin
			if (idx == `MBRF_PC_INDEX)
				rd_sel = gpr_q[15];
			else if (idx < 4'h8)
				rd_sel = gpr_q[idx]; // RULE_07
			else if (bk == `MBRF_BANK_FIQ)
				rd_sel = fast_bank_q[idx]; // RULE_09 RULE_15
			else if (idx == 4'hD && bk != `MBRF_BANK_USR)
				rd_sel = bank13_q[bk]; // RULE_08 RULE_16
			else if (idx == 4'hE && bk != `MBRF_BANK_USR)
				rd_sel = bank14_q[bk]; // RULE_08 RULE_16
			else
				rd_sel = gpr_q[idx]; // RULE_10
		end
	endfunction

	// Slots for exception entry and for the current mode
	assign exc_slot = slot_of(exc_bank);
	assign cur_slot = slot_of(bank);

	// Exception bank to mode code; never privileged user
	always @* begin
		case (exc_bank)
			`MBRF_BANK_FIQ: exc_mode = `MBRF_MODE_FIQ;
			`MBRF_BANK_IRQ: exc_mode = `MBRF_MODE_IRQ;
			`MBRF_BANK_ABT: exc_mode = `MBRF_MODE_ABT;
			`MBRF_BANK_UND: exc_mode = `MBRF_MODE_UND;
			default: exc_mode = `MBRF_MODE_SVC; // RULE_11
		endcase
	end

	// Unprivileged writes may only touch bits 31:8
	// Keeping 7:0 holds both the mode and the protected control bits
	assign status_masked = cur_status_wr_data & STATUS_MASK; // RULE_05
	assign user_merge = {status_masked[31:8], status_q[7:0]}; // RULE_12

	// Next status: exception beats a software write in the same cycle
	always @* begin
		status_d = status_q;
		blocked_d = 1'b0;
		if (exc_take) begin
			status_d = {status_q[31:5], exc_mode}; // RULE_14
		end else if (cur_status_wr_en && priv_w) begin
			status_d = status_masked; // RULE_13
		end else if (cur_status_wr_en) begin
			status_d = user_merge; // RULE_12
			blocked_d = (cur_status_wr_data[4:0] != status_q[4:0]);
		end
	end

	// Status register and blocked pulse
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			status_q <= {27'h0000000, RESET_CODE}; // RULE_18
			blocked_q <= 1'b0;
		end else begin
			status_q <= status_d;
			blocked_q <= blocked_d;
		end
	end

	// Saved status storage; contents undefined until written
	always @(posedge ref_clk) begin
		if (exc_take) begin
			saved_q[exc_slot] <= status_q & STATUS_MASK; // RULE_09
		end else if (saved_status_wr_en && exc_w) begin
			saved_q[cur_slot] <= saved_status_wr_data & STATUS_MASK; // RULE_09
		end
	end

	// General register storage; no reset, contents undefined until written
	// A same-cycle software write to the entered mode's index 14 copy loses to the return address
	always @(posedge ref_clk) begin
		if (pc_wr_en) begin
			gpr_q[15] <= pc_wr_data;
		end
		if (wr_en && wr_idx != `MBRF_PC_INDEX) begin
			if (wr_idx < 4'h8)
				gpr_q[wr_idx] <= wr_data; // RULE_07
			else if (bank == `MBRF_BANK_FIQ)
				fast_bank_q[wr_idx] <= wr_data; // RULE_09 RULE_15
			else if (wr_idx == 4'hD && bank != `MBRF_BANK_USR)
				bank13_q[bank] <= wr_data; // RULE_16
			else if (wr_idx == 4'hE && bank != `MBRF_BANK_USR)
				bank14_q[bank] <= wr_data; // RULE_16
			else
				gpr_q[wr_idx] <= wr_data; // RULE_08
		end
		if (exc_take) begin
			if (exc_slot == 3'h5)
				fast_bank_q[14] <= exc_return_addr; // RULE_14
			else
				bank14_q[exc_slot] <= exc_return_addr; // RULE_14
		end
	end

	// Read ports, zero latency
	assign rd_a_data = rd_sel(rd_a_idx, bank); // RULE_06
	assign rd_b_data = rd_sel(rd_b_idx, bank); // RULE_06

	// Status views and mode flags
	assign program_counter = gpr_q[15];
	assign current_status_reg = status_q;
	assign saved_status_valid = exc_w; // RULE_10
	assign saved_status_reg = exc_w ? saved_q[cur_slot] : 32'h00000000; // RULE_10
	assign mode = status_q[4:0];
	assign privileged = priv_w;
	assign in_exception_mode = exc_w;
	assign mode_change_blocked = blocked_q;
	assign resource_access_ok = priv_w; // RULE_12 RULE_13
endmodule

// ### testbench/mbrf_asserts.sv
// Checker for the mode-banked register file ports
`timescale 1ns/1ps
module mbrf_chk (
	input wire ref_clk,
	input wire rst,
	input wire cur_status_wr_en,
	input wire [31:0] cur_status_wr_data,
	input wire exc_take,
	input wire [2:0] exc_bank,
	input wire [31:0] current_status_reg,
	input wire [31:0] saved_status_reg,
	input wire saved_status_valid,
	input wire [4:0] mode,
	input wire privileged,
	input wire in_exception_mode,
	input wire mode_change_blocked,
	input wire resource_access_ok
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	// Status write attempted from unprivileged mode
	wire usr_wr = mode == 5'h10 && cur_status_wr_en && !exc_take;
	exc_decode_a: assert property (in_exception_mode == saved_status_valid &&
		saved_status_valid == (mode inside {5'h11, 5'h12, 5'h13, 5'h17, 5'h1B}))
		else $error("exception decode wrong");
	priv_decode_a: assert property (privileged == (mode inside
		{5'h11, 5'h12, 5'h13, 5'h17, 5'h1B, 5'h1F})) else $error("privilege decode wrong");
	access_ok_a: assert property (resource_access_ok == privileged)
		else $error("access flag wrong");
	no_saved_a: assert property (!saved_status_valid |-> saved_status_reg == 32'h0)
		else $error("saved status shown");
	exc_no_sys_a: assert property (exc_take |=> mode != 5'h1F)
		else $error("exception entered privileged user mode");
	fiq_entry_a: assert property (exc_take && exc_bank == 3'h5 |=> mode == 5'h11)
		else $error("fast interrupt entry wrong");
	user_lock_a: assert property (usr_wr |=> mode == 5'h10 &&
		current_status_reg[31:8] == $past(cur_status_wr_data[31:8])) else $error("user lock wrong");
	block_pulse_a: assert property (usr_wr && cur_status_wr_data[4:0] != 5'h10
		|=> mode_change_blocked) else $error("no blocked pulse");
	priv_write_a: assert property (privileged && cur_status_wr_en && !exc_take
		|=> current_status_reg == $past(cur_status_wr_data)) else $error("status write lost");
	cover property (usr_wr ##1 mode_change_blocked);
	cover property (exc_take ##1 saved_status_valid);
	cover property (mode == 5'h1F);
endmodule
bind mbrf_regfile mbrf_chk mbrf_chk_inst (.ref_clk, .rst, .cur_status_wr_en, .cur_status_wr_data,
	.exc_take, .exc_bank, .current_status_reg, .saved_status_reg, .saved_status_valid, .mode,
	.privileged, .in_exception_mode, .mode_change_blocked, .resource_access_ok);

// ### testbench/mbrf_dp_model.sv
// Datapath-side requester for the register file
`timescale 1ns/1ps
module mbrf_dp_model (
	input wire ref_clk,
	output reg wr_en,
	output reg [3:0] wr_idx,
	output reg [31:0] wr_data,
	output reg cur_status_wr_en,
	output reg [31:0] cur_status_wr_data,
	output reg exc_take,
	output reg [2:0] exc_bank,
	output reg [31:0] exc_return_addr
);
	initial begin
		{wr_en, cur_status_wr_en, exc_take, exc_bank, wr_idx} = 10'h0;
		{wr_data, cur_status_wr_data, exc_return_addr} = 96'h0;
	end
	// Kind 0 register write, 1 status write, 2 exception; held over one edge
	task req(input [1:0] k, input [3:0] i, input [31:0] d);
		begin
			@(posedge ref_clk);
			#1;
			{wr_idx, exc_bank} = {i, i[2:0]};
			{wr_data, cur_status_wr_data, exc_return_addr} = {d, d, d};
			{exc_take, cur_status_wr_en, wr_en} = 3'h1 << k;
			@(posedge ref_clk);
			#1;
			{exc_take, cur_status_wr_en, wr_en} = 3'h0;
			{wr_data, cur_status_wr_data, exc_return_addr} = ~{d, d, d};
		end
	endtask
endmodule

// ### testbench/mode_banked_register_file_test.sv
// Bench for the mode-banked register file
`timescale 1ns/1ps
module mode_banked_register_file_test;
	reg ref_clk = 0, rst = 1;
	reg [3:0] rd_a_idx = 4'h0;
	wire wr_en, cur_status_wr_en, exc_take, saved_status_valid, privileged, in_exception_mode;
	wire mode_change_blocked, resource_access_ok;
	wire [3:0] wr_idx;
	wire [2:0] exc_bank;
	wire [4:0] mode;
	wire [31:0] wr_data, cur_status_wr_data, exc_return_addr, rd_a_data, rd_b_data;
	wire [31:0] program_counter;
	reg pc_wr_en = 0, ss_wr_en = 0;
	reg [31:0] pc_wr_data = 32'h0, ss_wr_data = 32'h0;
	wire [31:0] current_status_reg, saved_status_reg;
	int err_total = 0, n_checks = 0, cyc = 0, p, r, q, i;
	reg [31:0] e;
	// Rows: mode code, privileged, saved status shown
	reg [6:0] rows [7] = '{7'h7E, 7'h4F, 7'h5F, 7'h6F, 7'h4B, 7'h47, 7'h40};
	reg [4:0] emode [5] = '{5'h13, 5'h17, 5'h1B, 5'h12, 5'h11};
	mbrf_dp_model mbrf_dp_model_inst (.ref_clk, .wr_en, .wr_idx, .wr_data, .cur_status_wr_en,
		.cur_status_wr_data, .exc_take, .exc_bank, .exc_return_addr);
	mbrf_regfile mbrf_regfile_inst (.ref_clk, .rst, .rd_a_idx, .rd_a_data, .rd_b_idx(rd_a_idx),
		.rd_b_data, .wr_en, .wr_idx, .wr_data, .pc_wr_en, .pc_wr_data,
		.program_counter, .current_status_reg, .cur_status_wr_en, .cur_status_wr_data,
		.saved_status_reg, .saved_status_valid, .saved_status_wr_en(ss_wr_en),
		.saved_status_wr_data(ss_wr_data), .exc_take, .exc_bank, .exc_return_addr, .mode,
		.privileged, .in_exception_mode, .mode_change_blocked, .resource_access_ok);
	initial begin
		forever #4 ref_clk = ~ref_clk;
	end
	// Hang guard
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 5000) begin
			err_total++;
			final_report;
		end
	end
	// Physical copy behind an index in a row's mode
	function int phys(int r, int i);
		return i < 8 ? i : i < 13 ? (r == 5 ? 16 + i : i) : (r % 6) * 32 + i;
	endfunction
	function [31:0] dat(int r, int i);
		return 32'hA5000000 + r * 256 + i;
	endfunction
	task chk(input [31:0] g, input [31:0] x);
		n_checks++;
		if (g !== x) begin
			err_total++;
			$display("MISMATCH %0t got %h exp %h", $time, g, x);
		end
	endtask
	task final_report;
		if (err_total == 0 && n_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	initial begin
		repeat (6) @(posedge ref_clk);
		#1 rst = 0;
		chk(current_status_reg, 32'h13);
		// Pass 0 fills every bank, pass 1 reads back
		for (p = 0; p < 2; p++) begin
			if (p == 1) mbrf_dp_model_inst.req(2, 1, dat(1, 14));
			for (r = 0; r < 7; r++) begin
				mbrf_dp_model_inst.req(1, 0, {27'h0, rows[r][6:2]});
				chk({mode, privileged, saved_status_valid}, rows[r]);
				for (i = 0; i < 15; i++) begin
					if (p == 0) mbrf_dp_model_inst.req(0, i, dat(r, i));
					rd_a_idx = i;
					#1;
					for (q = 0; q < 7; q++) if (phys(q, i) == phys(r, i)) e = dat(q, i);
					if (p == 1) chk(rd_a_data, e);
					if (p == 1) chk(rd_b_data, e);
				end
			end
		end
		mbrf_dp_model_inst.req(1, 0, 32'hAB000013);
		chk(current_status_reg, 32'hAB000010);
		chk({31'h0, mode_change_blocked}, 32'h1);
		for (i = 1; i < 6; i++) begin
			mbrf_dp_model_inst.req(2, i, 32'hE0 + i);
			rd_a_idx = 4'hE;
			#1;
			chk({27'h0, mode}, {27'h0, emode[i - 1]});
			chk(saved_status_reg, 32'hAB000010);
			chk(rd_a_data, 32'hE0 + i);
			mbrf_dp_model_inst.req(1, 0, 32'hAB000010);
		end
		mbrf_dp_model_inst.req(2, 1, 32'h0);
		@(posedge ref_clk);
		#1;
		pc_wr_en = 1;
		pc_wr_data = 32'h0000C0DE;
		ss_wr_en = 1;
		ss_wr_data = 32'h5A5A0013;
		@(posedge ref_clk);
		#1;
		pc_wr_en = 0;
		ss_wr_en = 0;
		rd_a_idx = 4'hF;
		#1;
		chk(program_counter, 32'h0000C0DE);
		chk(rd_a_data, 32'h0000C0DE);
		chk(saved_status_reg, 32'h5A5A0013);
		final_report;
	end
endmodule
